// file: hw/tlic_arbiter.sv
// fixed-order two-level selection of the winning source
`timescale 1ns/1ns
module tlic_arbiter
#(
    parameter int N = 18
)
(
    input  wire logic [N-1:0] pend,
    input  wire logic [N-1:0] level,
    input  wire logic         in_svc_hi,
    input  wire logic         in_svc_lo,
    output logic              valid,
    output logic [4:0]        id,
    output logic              id_hi
);
    logic [N-1:0] hi_req;
    logic [N-1:0] lo_req;
    logic         hi_ok;
    logic         lo_ok;

    always_comb
    begin
        hi_req = pend & level;
        lo_req = pend & ~level;
        // high preempts low only; nothing preempts high
        hi_ok  = ~in_svc_hi;
        lo_ok  = ~in_svc_hi & ~in_svc_lo;
        valid  = 1'b0;
        id     = 5'h00;
        id_hi  = 1'b0;
        // scan from lowest rank so the top rank wins
        for (int i = N - 1; i >= 0; i--)
        begin
            if (lo_ok && lo_req[i] && hi_req == '0)
            begin
                valid = 1'b1;
                id    = 5'(i);
                id_hi = 1'b0;
            end
        end
        for (int i = N - 1; i >= 0; i--)
        begin
            if (hi_ok && hi_req[i])
            begin
                valid = 1'b1;
                id    = 5'(i);
                id_hi = 1'b1;
            end
        end
    end
endmodule

// file: hw/tlic_ext_detect.sv
// one external line detector with programmable mode and sticky flag
`timescale 1ns/1ns
module tlic_ext_detect
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pin,
    input  wire logic [1:0] mode,
    input  wire logic       clear,
    output logic            flag_q
);
    logic pin_q;
    logic pin_d;
    logic flag_d;
    logic hit;

    always_comb
    begin
        pin_d = pin;
        unique case (mode)
            tlic_pkg::DET_BOTH: hit = pin ^ pin_q;
            tlic_pkg::DET_RISE: hit = pin & ~pin_q;
            tlic_pkg::DET_FALL: hit = ~pin & pin_q;
            tlic_pkg::DET_HIGH: hit = pin;
        endcase
        // a new detection wins over a service clear
        flag_d = hit | (flag_q & ~clear);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_q  <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            pin_q  <= pin_d;
            flag_q <= flag_d;
        end
    end

    a_rise_sets_flag: assert property (@(posedge clk) disable iff (rst)
        (mode == tlic_pkg::DET_RISE && pin && !pin_q) |=> flag_q)
        else $error("rising edge did not set flag");
endmodule

// file: hw/tlic_pkg.sv
// package: register map, field layout, vectors and codes for the controller
package tlic_pkg;
    localparam int          NUM_SRC       = 18;
    localparam int          ADDR_W        = 8;
    // register byte addresses, one 8-bit register each
    localparam logic [7:0]  OFF_EN_CORE   = 8'hA8;
    localparam logic [7:0]  OFF_EN_EXT    = 8'hB0;
    localparam logic [7:0]  OFF_PRI_EXT   = 8'hB1;
    localparam logic [7:0]  OFF_PRI_CORE  = 8'hB8;
    localparam logic [7:0]  OFF_EN_MISC   = 8'hC0;
    localparam logic [7:0]  OFF_PRI_MISC  = 8'hC1;
    localparam logic [7:0]  OFF_EXT_FLAG  = 8'hD8;
    localparam logic [7:0]  OFF_EXT_MODE  = 8'hD9;
    localparam logic [7:0]  OFF_STATUS    = 8'hE0;
    // index of the first byte address in the word numbering
    localparam int          IDX_SHIFT     = 2;
    // writable masks; reserved bits stay zero
    localparam logic [7:0]  MASK_EN_CORE  = 8'hBF;
    localparam logic [7:0]  MASK_EXT5     = 8'h1F;
    localparam logic [7:0]  MASK_EN_MISC  = 8'h7F;
    localparam logic [7:0]  MASK_PRI_CORE = 8'h3F;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    // field positions
    localparam int          BIT_GLOBAL    = 7;
    localparam int          BIT_WDT_EN    = 6;
    localparam int          BIT_ADC_EN    = 5;
    localparam int          BIT_IFC_EN    = 4;
    localparam int          BIT_SIO2_EN   = 3;
    localparam int          BIT_SIO1_EN   = 2;
    localparam int          BIT_T4_EN     = 1;
    localparam int          BIT_T3_EN     = 0;
    localparam int          BIT_WDT_PRI   = 4;
    localparam int          BIT_ADC_PRI   = 3;
    localparam int          BIT_IFC_PRI   = 2;
    localparam int          BIT_SIO2_PRI  = 1;
    localparam int          BIT_SIO1_PRI  = 0;
    // vector table
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam int          VEC_STEP_LOG2 = 3;
    localparam logic [7:0]  VEC_SPAN      = 8'h8B;
    // detect mode codes
    localparam logic [1:0]  DET_BOTH      = 2'h0;
    localparam logic [1:0]  DET_RISE      = 2'h1;
    localparam logic [1:0]  DET_FALL      = 2'h2;
    localparam logic [1:0]  DET_HIGH      = 2'h3;
    // source numbers in fixed order, highest first
    localparam int S_EX0 = 0;
    localparam int S_T0  = 1;
    localparam int S_EX1 = 2;
    localparam int S_T1  = 3;
    localparam int S_U0  = 4;
    localparam int S_T2  = 5;
    localparam int S_WDT = 6;
    localparam int S_IFC = 7;
    localparam int S_ADC = 8;
    localparam int S_EX2 = 9;
    localparam int S_EX3 = 10;
    localparam int S_EX4 = 11;
    localparam int S_S1  = 12;
    localparam int S_S2  = 13;
    localparam int S_EX5 = 14;
    localparam int S_EX6 = 15;
    localparam int S_T3  = 16;
    localparam int S_T4  = 17;
    typedef enum logic [1:0] {
        TLIC_BUS_IDLE = 2'b00,
        TLIC_BUS_RESP = 2'b01
    } tlic_bus_st_t;
endpackage

// file: hw/tlic_top.sv
// two-level interrupt controller with avalon-mm register slave
`timescale 1ns/1ns
module tlic_top
#(
    parameter int N = tlic_pkg::NUM_SRC
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [N-1:0] src_req,
    input  wire logic [4:0]  ext_pin,
    output logic [N-1:0]     src_clear,
    output logic             irq_pending,
    output logic [15:0]      irq_vector,
    input  wire logic        irq_ack,
    input  wire logic        irq_return
);
    logic [7:0]  en_core_q, en_core_d;
    logic [7:0]  en_ext_q, en_ext_d;
    logic [7:0]  en_misc_q, en_misc_d;
    logic [7:0]  pri_core_q, pri_core_d;
    logic [7:0]  pri_ext_q, pri_ext_d;
    logic [7:0]  pri_misc_q, pri_misc_d;
    logic [7:0]  det_mode_q, det_mode_d;
    logic        svc_hi_q, svc_hi_d;
    logic        svc_lo_q, svc_lo_d;
    logic        stk_lo_q, stk_lo_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d;
    logic        pend_q, pend_d;
    logic [15:0] vec_q, vec_d;
    logic [4:0]  won_q, won_d;
    logic        won_hi_q, won_hi_d;
    logic [N-1:0] clr_q, clr_d;
    tlic_pkg::tlic_bus_st_t bus_q, bus_d;

    logic [N-1:0] enable;
    logic [N-1:0] level;
    logic [N-1:0] req;
    logic [4:0]   ext_flag;
    logic [4:0]   ext_clr;
    logic         arb_valid;
    logic [4:0]   arb_id;
    logic         arb_hi;
    logic         wr_go;
    logic         rd_go;
    logic         take;

    // per-source enable, and level for all sources but T3 and T4 (left low), gathered in fixed source order
    always_comb
    begin
        enable = '0;
        level  = '0;
        enable[tlic_pkg::S_EX0] = en_core_q[0];
        enable[tlic_pkg::S_T0]  = en_core_q[1];
        enable[tlic_pkg::S_EX1] = en_core_q[2];
        enable[tlic_pkg::S_T1]  = en_core_q[3];
        enable[tlic_pkg::S_U0]  = en_core_q[4];
        enable[tlic_pkg::S_T2]  = en_core_q[5];
        enable[tlic_pkg::S_WDT] = en_misc_q[tlic_pkg::BIT_WDT_EN];
        enable[tlic_pkg::S_ADC] = en_misc_q[tlic_pkg::BIT_ADC_EN];
        enable[tlic_pkg::S_IFC] = en_misc_q[tlic_pkg::BIT_IFC_EN];
        enable[tlic_pkg::S_S2]  = en_misc_q[tlic_pkg::BIT_SIO2_EN];
        enable[tlic_pkg::S_S1]  = en_misc_q[tlic_pkg::BIT_SIO1_EN];
        enable[tlic_pkg::S_T4]  = en_misc_q[tlic_pkg::BIT_T4_EN];
        enable[tlic_pkg::S_T3]  = en_misc_q[tlic_pkg::BIT_T3_EN];
        enable[tlic_pkg::S_EX2] = en_ext_q[0];
        enable[tlic_pkg::S_EX3] = en_ext_q[1];
        enable[tlic_pkg::S_EX4] = en_ext_q[2];
        enable[tlic_pkg::S_EX5] = en_ext_q[3];
        enable[tlic_pkg::S_EX6] = en_ext_q[4];
        level[tlic_pkg::S_EX0]  = pri_core_q[0];
        level[tlic_pkg::S_T0]   = pri_core_q[1];
        level[tlic_pkg::S_EX1]  = pri_core_q[2];
        level[tlic_pkg::S_T1]   = pri_core_q[3];
        level[tlic_pkg::S_U0]   = pri_core_q[4];
        level[tlic_pkg::S_T2]   = pri_core_q[5];
        level[tlic_pkg::S_WDT]  = pri_misc_q[tlic_pkg::BIT_WDT_PRI];
        level[tlic_pkg::S_ADC]  = pri_misc_q[tlic_pkg::BIT_ADC_PRI];
        level[tlic_pkg::S_IFC]  = pri_misc_q[tlic_pkg::BIT_IFC_PRI];
        level[tlic_pkg::S_S2]   = pri_misc_q[tlic_pkg::BIT_SIO2_PRI];
        level[tlic_pkg::S_S1]   = pri_misc_q[tlic_pkg::BIT_SIO1_PRI];
        level[tlic_pkg::S_EX2]  = pri_ext_q[0];
        level[tlic_pkg::S_EX3]  = pri_ext_q[1];
        level[tlic_pkg::S_EX4]  = pri_ext_q[2];
        level[tlic_pkg::S_EX5]  = pri_ext_q[3];
        level[tlic_pkg::S_EX6]  = pri_ext_q[4];
    end

    // ext2..ext5 have mode fields; ext6 is fixed to rising edge
    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_ext
            logic [1:0] mode_w;
            if (g < 4)
            begin : g_prog
                assign mode_w = det_mode_q[2*g +: 2];
            end
            else
            begin : g_fixed
                assign mode_w = tlic_pkg::DET_RISE;
            end
            tlic_ext_detect u_det
            (
                .clk    (clk),
                .rst    (rst),
                .pin    (ext_pin[g]),
                .mode   (mode_w),
                .clear  (ext_clr[g]),
                .flag_q (ext_flag[g])
            );
        end
    endgenerate

    always_comb
    begin
        req = src_req;
        req[tlic_pkg::S_EX2] = ext_flag[0];
        req[tlic_pkg::S_EX3] = ext_flag[1];
        req[tlic_pkg::S_EX4] = ext_flag[2];
        req[tlic_pkg::S_EX5] = ext_flag[3];
        req[tlic_pkg::S_EX6] = ext_flag[4];
        // gate off stops everything
        req = req & enable & {N{en_core_q[tlic_pkg::BIT_GLOBAL]}};
        ext_clr[0] = clr_q[tlic_pkg::S_EX2];
        ext_clr[1] = clr_q[tlic_pkg::S_EX3];
        ext_clr[2] = clr_q[tlic_pkg::S_EX4];
        ext_clr[3] = clr_q[tlic_pkg::S_EX5];
        ext_clr[4] = clr_q[tlic_pkg::S_EX6];
    end

    tlic_arbiter #(.N(N)) u_arb
    (
        .pend      (req),
        .level     (level),
        .in_svc_hi (svc_hi_q),
        .in_svc_lo (svc_lo_q),
        .valid     (arb_valid),
        .id        (arb_id),
        .id_hi     (arb_hi)
    );

    // interrupt handshake and in-service markers
    always_comb
    begin
        take     = irq_ack & pend_q;
        pend_d   = arb_valid & ~take;
        won_d    = arb_id;
        won_hi_d = arb_hi;
        vec_d    = tlic_pkg::VEC_BASE
                 + (16'(arb_id) << tlic_pkg::VEC_STEP_LOG2);
        clr_d    = '0;
        svc_hi_d = svc_hi_q;
        svc_lo_d = svc_lo_q;
        stk_lo_d = stk_lo_q;
        if (take)
        begin
            // vectoring clears the taken source's request flag
            clr_d[won_q] = 1'b1;
            if (won_hi_q)
            begin
                svc_hi_d = 1'b1;
                stk_lo_d = svc_lo_q;
            end
            else
                svc_lo_d = 1'b1;
        end
        else if (irq_return)
        begin
            if (svc_hi_q)
            begin
                svc_hi_d = 1'b0;
                svc_lo_d = stk_lo_q;
            end
            else
                svc_lo_d = 1'b0;
        end
    end

    // avalon slave: one wait cycle, then answer
    always_comb
    begin
        bus_d   = bus_q;
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        wr_go   = 1'b0;
        rd_go   = 1'b0;
        unique case (bus_q)
            tlic_pkg::TLIC_BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    bus_d  = tlic_pkg::TLIC_BUS_RESP;
                    wait_d = 1'b0;
                    wr_go  = avs_write & avs_byteenable[0];
                    rd_go  = avs_read;
                end
            end
            tlic_pkg::TLIC_BUS_RESP:
                bus_d = tlic_pkg::TLIC_BUS_IDLE;
            default:
                bus_d = tlic_pkg::TLIC_BUS_IDLE;
        endcase
        en_core_d  = en_core_q;
        en_ext_d   = en_ext_q;
        en_misc_d  = en_misc_q;
        pri_core_d = pri_core_q;
        pri_ext_d  = pri_ext_q;
        pri_misc_d = pri_misc_q;
        det_mode_d = det_mode_q;
        if (wr_go)
        begin
            // reserved bits are masked so they stay zero
            unique case (avs_address)
                tlic_pkg::OFF_EN_CORE:
                    en_core_d = avs_writedata[7:0] & tlic_pkg::MASK_EN_CORE;
                tlic_pkg::OFF_EN_EXT:
                    en_ext_d = avs_writedata[7:0] & tlic_pkg::MASK_EXT5;
                tlic_pkg::OFF_EN_MISC:
                    en_misc_d = avs_writedata[7:0] & tlic_pkg::MASK_EN_MISC;
                tlic_pkg::OFF_PRI_CORE:
                    pri_core_d = avs_writedata[7:0] & tlic_pkg::MASK_PRI_CORE;
                tlic_pkg::OFF_PRI_EXT:
                    pri_ext_d = avs_writedata[7:0] & tlic_pkg::MASK_EXT5;
                tlic_pkg::OFF_PRI_MISC:
                    pri_misc_d = avs_writedata[7:0] & tlic_pkg::MASK_EXT5;
                tlic_pkg::OFF_EXT_MODE:
                    det_mode_d = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (rd_go)
        begin
            rdata_d = '0;
            unique case (avs_address)
                tlic_pkg::OFF_EN_CORE:  rdata_d[7:0] = en_core_q;
                tlic_pkg::OFF_EN_EXT:   rdata_d[7:0] = en_ext_q;
                tlic_pkg::OFF_EN_MISC:  rdata_d[7:0] = en_misc_q;
                tlic_pkg::OFF_PRI_CORE: rdata_d[7:0] = pri_core_q;
                tlic_pkg::OFF_PRI_EXT:  rdata_d[7:0] = pri_ext_q;
                tlic_pkg::OFF_PRI_MISC: rdata_d[7:0] = pri_misc_q;
                tlic_pkg::OFF_EXT_MODE: rdata_d[7:0] = det_mode_q;
                tlic_pkg::OFF_EXT_FLAG: rdata_d[4:0] = ext_flag;
                tlic_pkg::OFF_STATUS:
                    rdata_d[7:0] = {svc_hi_q, svc_lo_q, won_hi_q, won_q};
                default:                rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            en_core_q  <= tlic_pkg::RST_BYTE;
            en_ext_q   <= tlic_pkg::RST_BYTE;
            en_misc_q  <= tlic_pkg::RST_BYTE;
            pri_core_q <= tlic_pkg::RST_BYTE;
            pri_ext_q  <= tlic_pkg::RST_BYTE;
            pri_misc_q <= tlic_pkg::RST_BYTE;
            det_mode_q <= tlic_pkg::RST_BYTE;
            svc_hi_q   <= 1'b0;
            svc_lo_q   <= 1'b0;
            stk_lo_q   <= 1'b0;
            rdata_q    <= '0;
            wait_q     <= 1'b1;
            pend_q     <= 1'b0;
            vec_q      <= tlic_pkg::VEC_BASE;
            won_q      <= 5'h00;
            won_hi_q   <= 1'b0;
            clr_q      <= '0;
            bus_q      <= tlic_pkg::TLIC_BUS_IDLE;
        end
        else
        begin
            en_core_q  <= en_core_d;
            en_ext_q   <= en_ext_d;
            en_misc_q  <= en_misc_d;
            pri_core_q <= pri_core_d;
            pri_ext_q  <= pri_ext_d;
            pri_misc_q <= pri_misc_d;
            det_mode_q <= det_mode_d;
            svc_hi_q   <= svc_hi_d;
            svc_lo_q   <= svc_lo_d;
            stk_lo_q   <= stk_lo_d;
            rdata_q    <= rdata_d;
            wait_q     <= wait_d;
            pend_q     <= pend_d;
            vec_q      <= vec_d;
            won_q      <= won_d;
            won_hi_q   <= won_hi_d;
            clr_q      <= clr_d;
            bus_q      <= bus_d;
        end
    end

    always_comb
    begin
        avs_readdata    = rdata_q;
        avs_waitrequest = wait_q;
        irq_pending     = pend_q;
        irq_vector      = vec_q;
        src_clear       = clr_q;
    end

    a_gate_blocks_all: assert property (@(posedge clk) disable iff (rst)
        !en_core_q[tlic_pkg::BIT_GLOBAL] |=> !pend_q)
        else $error("pending raised with global gate off");
    a_vector_in_table: assert property (@(posedge clk) disable iff (rst)
        pend_q |-> vec_q[2:0] == 3'h3 && vec_q[7:0] <= tlic_pkg::VEC_SPAN)
        else $error("vector outside table");
    a_vector_matches: assert property (@(posedge clk) disable iff (rst)
        pend_q |-> vec_q == tlic_pkg::VEC_BASE + {won_q, 3'b000})
        else $error("vector does not match winner");
    a_no_preempt_hi: assert property (@(posedge clk) disable iff (rst)
        svc_hi_q |=> !pend_q)
        else $error("request pending during high service");
    a_lo_svc_only_hi: assert property (@(posedge clk) disable iff (rst)
        (svc_lo_q && pend_q) |-> won_hi_q)
        else $error("low request offered during low service");
    a_ack_clears_src: assert property (@(posedge clk) disable iff (rst)
        (irq_ack && pend_q) |=> clr_q[$past(won_q)] ##1 !clr_q[$past(won_q, 2)])
        else $error("taken source not cleared for one cycle");
    a_ack_sets_marker: assert property (@(posedge clk) disable iff (rst)
        (irq_ack && pend_q && won_hi_q) |=> svc_hi_q)
        else $error("high marker not set on acknowledge");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        en_ext_q[7:5] == 3'h0 && pri_ext_q[7:5] == 3'h0
        && en_core_q[6] == 1'b0)
        else $error("reserved bit became one");
    a_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
        ((avs_read || avs_write) && bus_q == tlic_pkg::TLIC_BUS_IDLE)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after exactly one cycle");
    c_hi_preempts_lo: cover property (@(posedge clk) disable iff (rst)
        svc_lo_q && irq_ack && pend_q && won_hi_q);
    c_lo_served: cover property (@(posedge clk) disable iff (rst)
        irq_ack && pend_q && !won_hi_q);
    c_return_hi: cover property (@(posedge clk) disable iff (rst)
        svc_hi_q && irq_return);
endmodule

// file: test/test_tlic_top.sv
// register and interrupt sequence tests for the controller
`timescale 1ns/1ns
module test_tlic_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [4:0]  ext_pin = 5'h00;
    logic [17:0] set_req = 18'h00000;
    logic        ack_en = 1'b0;
    logic        ret_cmd = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [17:0] src_req;
    logic [17:0] src_clear;
    logic        irq_pending;
    logic [15:0] irq_vector;
    logic        irq_ack;
    logic        irq_return;
    logic        taken;
    logic [15:0] taken_vec;
    logic [31:0] rdv;
    int          n_errors = 0;
    int          n_tests = 0;
    always #5 clk = ~clk;
    tlic_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .src_req(src_req), .ext_pin(ext_pin), .src_clear(src_clear),
        .irq_pending(irq_pending), .irq_vector(irq_vector),
        .irq_ack(irq_ack), .irq_return(irq_return));
    tlic_core_model partner (.clk(clk), .rst(rst), .set_req(set_req),
        .ack_en(ack_en), .ret_cmd(ret_cmd), .irq_pending(irq_pending),
        .irq_vector(irq_vector), .src_clear(src_clear), .src_req(src_req),
        .irq_ack(irq_ack), .irq_return(irq_return), .taken(taken),
        .taken_vec(taken_vec));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= w;
        avs_read      <= ~w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 40);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d, rdv);
    endtask
    task automatic raise(input logic [17:0] m);
        @(posedge clk);
        set_req <= m;
        @(posedge clk);
        set_req <= 18'h00000;
    endtask
    task automatic take(input logic [15:0] v);
        int n;
        n = 0;
        @(posedge clk);
        ack_en <= 1'b1;
        do @(negedge clk); while (taken !== 1'b1 && ++n < 40);
        @(posedge clk);
        ack_en <= 1'b0;
        chk("vector", {16'h0000, v}, {16'h0000, taken_vec});
    endtask
    task automatic ret();
        @(posedge clk);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
    endtask
    task automatic quiet();
        logic h;
        h = 1'b0;
        repeat (8) @(negedge clk) h = h | irq_pending;
        chk("blocked", 32'h00000000, {31'h0, h});
    endtask
    initial
    begin
        logic [7:0] offs [6];
        logic [7:0] msks [6];
        offs = '{8'hA8, 8'hB0, 8'hB1, 8'hB8, 8'hC0, 8'hC1};
        msks = '{8'hBF, 8'h1F, 8'h1F, 8'h3F, 8'h7F, 8'h1F};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b0, offs[i], 8'h00, rdv);
            chk("reset", 32'h00000000, rdv);
            wr(offs[i], 8'hFF);
            bus(1'b0, offs[i], 8'h00, rdv);
            chk("mask", {24'h0, msks[i]}, rdv);
            wr(offs[i], 8'h00);
        end
        wr(8'h10, 8'hFF);
        bus(1'b0, 8'h10, 8'h00, rdv);
        chk("unmapped", 32'h00000000, rdv);
        wr(8'hA8, 8'h02);
        raise(18'h00002);
        quiet();
        wr(8'hA8, 8'h82);
        take(16'h000B);
        @(negedge clk);
        chk("cleared", 32'h0, {31'h0, src_req[1]});
        ret();
        wr(8'hA8, 8'hBF);
        wr(8'hB0, 8'h1F);
        wr(8'hC0, 8'h3F);
        raise(18'h00040);
        quiet();
        wr(8'hC0, 8'h7F);
        take(16'h0033);
        ret();
        for (int i = 0; i < 18; i++)
        begin
            if (i inside {9, 10, 11, 14, 15})
                continue;
            raise(18'h00001 << i);
            take(16'h0003 + 16'(i * 8));
            ret();
        end
        raise(18'h10001);
        take(16'h0003);
        ret();
        take(16'h0083);
        ret();
        wr(8'hC1, 8'h10);
        raise(18'h00042);
        take(16'h0033);
        ret();
        take(16'h000B);
        raise(18'h00008);
        quiet();
        raise(18'h00040);
        take(16'h0033);
        raise(18'h00080);
        ret();
        quiet();
        ret();
        take(16'h001B);
        ret();
        take(16'h003B);
        ret();
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hD9, 8'(m));
            @(posedge clk);
            ext_pin <= 5'h01;
            repeat (4) @(posedge clk);
            bus(1'b0, 8'hD8, 8'h00, rdv);
            chk("rise flag", {31'h0, m != 2}, rdv);
            ext_pin <= 5'h00;
            repeat (4) @(posedge clk);
            bus(1'b0, 8'hD8, 8'h00, rdv);
            chk("fall flag", 32'h00000001, rdv);
            take(16'h004B);
            bus(1'b0, 8'hD8, 8'h00, rdv);
            chk("serviced", 32'h00000000, rdv);
            ret();
        end
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule

// file: test/tlic_core_model.sv
// partner model: peripheral request flags and a core that takes interrupts
`timescale 1ns/1ns
module tlic_core_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [17:0] set_req,
    input  wire logic        ack_en,
    input  wire logic        ret_cmd,
    input  wire logic        irq_pending,
    input  wire logic [15:0] irq_vector,
    input  wire logic [17:0] src_clear,
    output logic      [17:0] src_req,
    output logic             irq_ack,
    output logic             irq_return,
    output logic             taken,
    output logic      [15:0] taken_vec
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            src_req    <= 18'h00000;
            irq_ack    <= 1'b0;
            irq_return <= 1'b0;
            taken      <= 1'b0;
            taken_vec  <= 16'h0000;
        end
        else
        begin
            src_req    <= (src_req & ~src_clear) | set_req;
            // one acknowledge per offer, at an instruction boundary
            irq_ack    <= irq_pending & ack_en & ~irq_ack;
            irq_return <= ret_cmd;
            taken      <= irq_ack & irq_pending;
            if (irq_ack & irq_pending)
                taken_vec <= irq_vector;
        end
    end
endmodule
